// *** swx_exec.sv ***
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "swx_params.svh"
module swx_exec (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic      [13:0] rom_addr_o,
  output logic             rom_rd_o,
  input  wire logic [15:0] rom_data_i
);
  import swx_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  swx_state_t             state, next_state;
  logic [23:0]            instr, next_instr;
  logic [7:0]             acc, next_acc;
  logic [7:0]             table_pointer_low, next_table_pointer_low;
  logic [`SWX_PAGE_W-1:0] table_pointer_high, next_table_pointer_high;
  logic [7:0]             table_high_latch, next_table_high_latch;
  logic [7:0]             maddr, next_maddr;
  logic                   zero, next_zero;
  logic                   carry, next_carry;
  logic                   half, next_half;
  logic                   wrap, next_wrap;
  logic                   skip_flag, next_skip_flag;
  logic [31:0]            next_prdata;
  logic                   next_pready, next_pslverr;
  logic [13:0]            next_rom_addr;
  logic                   next_rom_rd;

  logic                   mem_we, mem_re;
  logic [7:0]             mem_addr, mem_wdata, mem_rdata;
  logic [7:0]             alu_res;
  logic                   alu_skip, alu_zero, alu_carry, alu_half, alu_wrap;
  logic                   bus_req, run;
  swx_op_t                op, new_op;
  logic [7:0]             status;

  assign op     = swx_op_t'(instr[`SWX_OP_MSB:0]);
  assign new_op = swx_op_t'(pwdata_i[`SWX_OP_MSB:0]);
  assign run    = state == ST_EXEC;
  // an access phase not yet answered
  assign bus_req = psel_i && penable_i && !pready_o;
  assign status  = {3'h0, skip_flag, wrap, half, carry, zero};

  swx_dmem u_dmem (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .we_i    (mem_we),
    .re_i    (mem_re),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  swx_alu u_alu (
    .acc_i   (acc),
    .mem_i   (mem_rdata),
    .imm_i   (instr[`SWX_IMM_MSB:`SWX_IMM_LSB]),
    .bsel_i  (instr[`SWX_BIT_MSB:`SWX_BIT_LSB]),
    .op_i    (op),
    .res_o   (alu_res),
    .skip_o  (alu_skip),
    .zero_o  (alu_zero),
    .carry_o (alu_carry),
    .half_o  (alu_half),
    .wrap_o  (alu_wrap)
  );

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_instr     = instr;
    next_acc       = acc;
    next_table_pointer_low  = table_pointer_low;
    next_table_pointer_high = table_pointer_high;
    next_table_high_latch   = table_high_latch;
    next_maddr     = maddr;
    next_zero      = zero;
    next_carry     = carry;
    next_half      = half;
    next_wrap      = wrap;
    next_skip_flag = skip_flag;
    next_prdata    = prdata_o;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    next_rom_addr  = rom_addr_o;
    next_rom_rd    = 1'b0;
    mem_we         = 1'b0;
    mem_re         = 1'b0;
    mem_addr       = maddr;
    mem_wdata      = pwdata_i[7:0];
    case (state)
      ST_IDLE: begin
        // bus is served only between instructions; the master waits
        if (bus_req) begin
          next_pready = 1'b1;
          next_prdata = 32'h0000_0000;
          if (pwrite_i) begin
            if (paddr_i == `SWX_REG_INSTR) begin
              next_instr = pwdata_i[23:0];
              next_state = ST_READ;
              next_rom_addr = {table_pointer_high, table_pointer_low};
              if (new_op == OP_TRDL) begin
                next_rom_addr = {`SWX_LAST_PAGE, table_pointer_low};
              end
              next_rom_rd = (new_op == OP_TRDC) || (new_op == OP_TRDL);
            end else if (paddr_i == `SWX_REG_ACC) begin
              next_acc = pwdata_i[7:0];
            end else if (paddr_i == `SWX_REG_STATUS) begin
              next_zero      = pwdata_i[`SWX_ST_ZERO];
              next_carry     = pwdata_i[`SWX_ST_CARRY];
              next_half      = pwdata_i[`SWX_ST_HALF];
              next_wrap      = pwdata_i[`SWX_ST_WRAP];
              next_skip_flag = pwdata_i[`SWX_ST_SKIP];
            end else if (paddr_i == `SWX_REG_TABLE_POINTER_LOW) begin
              next_table_pointer_low = pwdata_i[7:0];
            end else if (paddr_i == `SWX_REG_TABLE_POINTER_HIGH) begin
              next_table_pointer_high = pwdata_i[`SWX_PAGE_W-1:0];
            end else if (paddr_i == `SWX_REG_MADDR) begin
              next_maddr = pwdata_i[7:0];
            end else if (paddr_i == `SWX_REG_MDATA) begin
              mem_we = 1'b1;
            end else if (paddr_i != `SWX_REG_TABLE_HIGH_LATCH) begin
              next_pslverr = 1'b1;
            end
          end else begin
            if (paddr_i == `SWX_REG_INSTR) begin
              next_prdata = {8'h00, instr};
            end else if (paddr_i == `SWX_REG_ACC) begin
              next_prdata = {24'h0, acc};
            end else if (paddr_i == `SWX_REG_STATUS) begin
              next_prdata = {24'h0, status};
            end else if (paddr_i == `SWX_REG_TABLE_POINTER_LOW) begin
              next_prdata = {24'h0, table_pointer_low};
            end else if (paddr_i == `SWX_REG_TABLE_POINTER_HIGH) begin
              next_prdata = {26'h0, table_pointer_high};
            end else if (paddr_i == `SWX_REG_TABLE_HIGH_LATCH) begin
              next_prdata = {24'h0, table_high_latch};
            end else if (paddr_i == `SWX_REG_MADDR) begin
              next_prdata = {24'h0, maddr};
            end else if (paddr_i == `SWX_REG_MDATA) begin
              // memory read data is registered, answer one cycle later
              mem_re      = 1'b1;
              next_pready = 1'b0;
              next_state  = ST_BUSRD;
            end else begin
              next_pslverr = 1'b1;
            end
          end
        end
      end
      ST_BUSRD: begin
        next_prdata = {24'h0, mem_rdata};
        next_pready = 1'b1;
        next_state  = ST_IDLE;
      end
      ST_READ: begin
        mem_re     = 1'b1;
        mem_addr   = instr[`SWX_MADR_MSB:`SWX_MADR_LSB];
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        mem_addr   = instr[`SWX_MADR_MSB:`SWX_MADR_LSB];
        mem_wdata  = alu_res;
        next_state = ST_IDLE;
        case (op)
          OP_SWAP: mem_we = 1'b1;
          OP_NIBBLE_EXCHANGE_TO_WORKING: next_acc = alu_res;
          OP_COPY_AND_SKIP_WHEN_NULL: next_acc = mem_rdata;
          OP_TRDC, OP_TRDL: begin
            mem_we    = 1'b1;
            mem_wdata = rom_data_i[7:0];
            next_table_high_latch = rom_data_i[15:8];
          end
          OP_XOR, OP_XORI: begin
            next_acc  = alu_res;
            next_zero = alu_zero;
          end
          OP_XOR_INTO_MEMORY: begin
            mem_we    = 1'b1;
            next_zero = alu_zero;
          end
          OP_SUBI: begin
            next_acc   = alu_res;
            next_zero  = alu_zero;
            next_carry = alu_carry;
            next_half  = alu_half;
            next_wrap  = alu_wrap;
          end
          default: next_acc = acc;
        endcase
        next_skip_flag = alu_skip;
        if (alu_skip) begin
          next_state = ST_DUMMY;
        end
      end
      ST_DUMMY: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= ST_IDLE;
      instr      <= 24'h00_0000;
      acc        <= `SWX_BYTE_RESET;
      table_pointer_low  <= `SWX_BYTE_RESET;
      table_pointer_high <= 6'h00;
      table_high_latch   <= `SWX_BYTE_RESET;
      maddr      <= `SWX_BYTE_RESET;
      zero       <= 1'b0;
      carry      <= 1'b0;
      half       <= 1'b0;
      wrap       <= 1'b0;
      skip_flag  <= 1'b0;
      prdata_o   <= 32'h0000_0000;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      rom_addr_o <= 14'h0000;
      rom_rd_o   <= 1'b0;
    end else begin
      state      <= next_state;
      instr      <= next_instr;
      acc        <= next_acc;
      table_pointer_low  <= next_table_pointer_low;
      table_pointer_high <= next_table_pointer_high;
      table_high_latch   <= next_table_high_latch;
      maddr      <= next_maddr;
      zero       <= next_zero;
      carry      <= next_carry;
      half       <= next_half;
      wrap       <= next_wrap;
      skip_flag  <= next_skip_flag;
      prdata_o   <= next_prdata;
      pready_o   <= next_pready;
      pslverr_o  <= next_pslverr;
      rom_addr_o <= next_rom_addr;
      rom_rd_o   <= next_rom_rd;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_swap_mem_write : assert property (
    run && op == OP_SWAP |-> mem_we && mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]} ##1 $stable(status[3:0]))
    else $error("swap to memory wrong");
  a_swap_to_acc : assert property (
    run && op == OP_NIBBLE_EXCHANGE_TO_WORKING |->
      !mem_we ##1 acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("swap to accumulator wrong");
  a_null_skip : assert property (
    run && op == OP_SKIP_WHEN_NULL |-> !mem_we ##1 (state == ST_DUMMY) == ($past(mem_rdata) == 8'h00))
    else $error("null skip decision wrong");
  a_skip_two_cycle : assert property (
    run && alu_skip |=> state == ST_DUMMY ##1 state == ST_IDLE)
    else $error("skip does not take one dummy cycle");
  a_copy_skip : assert property (
    run && op == OP_COPY_AND_SKIP_WHEN_NULL |=>
      acc == $past(mem_rdata) && skip_flag == (acc == 8'h00) && $stable(status[3:0]))
    else $error("copy and skip wrong");
  a_bit_skip : assert property (
    run && op == OP_SZBIT |=> skip_flag == !$past(mem_rdata[instr[6:4]]))
    else $error("bit skip wrong");
  a_table_route : assert property (
    run && (op == OP_TRDC || op == OP_TRDL) |->
      mem_we && mem_wdata == rom_data_i[7:0] ##1 table_high_latch == $past(rom_data_i[15:8]))
    else $error("table read routing wrong");
  a_last_page : assert property (
    state == ST_READ && op == OP_TRDL |-> rom_rd_o && rom_addr_o == {`SWX_LAST_PAGE, table_pointer_low})
    else $error("last page address wrong");
  a_xor_acc : assert property (
    run && op == OP_XOR |=> acc == ($past(acc) ^ $past(mem_rdata)) && $stable(status[3:1]))
    else $error("xor to accumulator wrong");
  a_xor_mem : assert property (
    run && op == OP_XOR_INTO_MEMORY |->
      mem_we && mem_wdata == (acc ^ mem_rdata) ##1 zero == ($past(mem_wdata) == 8'h00))
    else $error("xor to memory wrong");
  a_xor_imm : assert property (
    run && op == OP_XORI |=> acc == ($past(acc) ^ $past(instr[23:16])))
    else $error("xor immediate wrong");
  a_sub_imm : assert property (
    run && op == OP_SUBI |=> acc == 8'($past(acc) - $past(instr[23:16])) && carry == ($past(acc) >= $past(instr[23:16])))
    else $error("immediate subtract wrong");
  a_zero_flag : assert property (
    run && (op == OP_XOR || op == OP_XORI || op == OP_SUBI) |=> zero == (acc == 8'h00))
    else $error("zero flag wrong");

  c_skip_taken : cover property (run && alu_skip ##1 state == ST_DUMMY);
  c_table_read : cover property (run && op == OP_TRDC);
  c_sub_borrow : cover property (run && op == OP_SUBI && !alu_carry);
  c_bus_wait   : cover property (bus_req && state == ST_EXEC);
endmodule
`default_nettype wire

// *** swx_params.svh ***
`ifndef SWX_PARAMS_SVH
`define SWX_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SWX_REG_INSTR  8'h00
`define SWX_REG_ACC    8'h04
`define SWX_REG_STATUS 8'h08
`define SWX_REG_TABLE_POINTER_LOW  8'h0c
`define SWX_REG_TABLE_POINTER_HIGH 8'h10
`define SWX_REG_TABLE_HIGH_LATCH   8'h14
`define SWX_REG_MADDR  8'h18
`define SWX_REG_MDATA  8'h1c

// ------------------------------------------------------------
// field positions and sizes
// ------------------------------------------------------------
`define SWX_OP_MSB     3
`define SWX_BIT_LSB    4
`define SWX_BIT_MSB    6
`define SWX_MADR_LSB   8
`define SWX_MADR_MSB   15
`define SWX_IMM_LSB    16
`define SWX_IMM_MSB    23
`define SWX_ST_ZERO    0
`define SWX_ST_CARRY   1
`define SWX_ST_HALF    2
`define SWX_ST_WRAP    3
`define SWX_ST_SKIP    4
`define SWX_MEM_WORDS  192
`define SWX_PAGE_W     6
`define SWX_LAST_PAGE  6'h3f
`define SWX_BYTE_RESET 8'h00
`endif

// *** swx_pkg.sv ***
package swx_pkg;
  typedef enum logic [3:0] {
    OP_SWAP, OP_NIBBLE_EXCHANGE_TO_WORKING, OP_SKIP_WHEN_NULL, OP_COPY_AND_SKIP_WHEN_NULL,
    OP_SZBIT, OP_TRDC, OP_TRDL, OP_XOR, OP_XOR_INTO_MEMORY, OP_XORI, OP_SUBI
  } swx_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BUSRD, ST_READ, ST_EXEC, ST_DUMMY
  } swx_state_t;

  function automatic logic swx_is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction
endpackage

// *** swx_dmem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "swx_params.svh"
module swx_dmem (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output var  logic [7:0] rdata_o
);
  logic [7:0] mem [0:`SWX_MEM_WORDS-1];
  logic [7:0] next_rdata;
  logic       in_range;

  // addresses above the array read zero and drop writes
  always_comb begin
    in_range   = addr_i < 8'(`SWX_MEM_WORDS);
    next_rdata = rdata_o;
    if (re_i) begin
      next_rdata = in_range ? mem[addr_i] : `SWX_BYTE_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (we_i && in_range) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= `SWX_BYTE_RESET;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// *** swx_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module swx_alu (
  input  wire logic            [7:0] acc_i,
  input  wire logic            [7:0] mem_i,
  input  wire logic            [7:0] imm_i,
  input  wire logic            [2:0] bsel_i,
  input  wire swx_pkg::swx_op_t      op_i,
  output logic                 [7:0] res_o,
  output logic                       skip_o,
  output logic                       zero_o,
  output logic                       carry_o,
  output logic                       half_o,
  output logic                       wrap_o
);
  import swx_pkg::*;
  logic [8:0] sum;
  logic [4:0] low;

  always_comb begin
    // subtract as add of inverted operand plus one
    sum     = {1'b0, acc_i} + {1'b0, ~imm_i} + 9'h001;
    low     = {1'b0, acc_i[3:0]} + {1'b0, ~imm_i[3:0]} + 5'h01;
    res_o   = mem_i;
    skip_o  = 1'b0;
    carry_o = sum[8];
    half_o  = low[4];
    wrap_o  = (acc_i[7] ^ imm_i[7]) & (acc_i[7] ^ sum[7]);
    case (op_i)
      OP_SWAP, OP_NIBBLE_EXCHANGE_TO_WORKING: res_o = {mem_i[3:0], mem_i[7:4]};
      OP_SKIP_WHEN_NULL, OP_COPY_AND_SKIP_WHEN_NULL: skip_o = swx_is_zero(mem_i);
      OP_SZBIT: skip_o = ~mem_i[bsel_i];
      OP_XOR, OP_XOR_INTO_MEMORY: res_o = acc_i ^ mem_i;
      OP_XORI: res_o = acc_i ^ imm_i;
      OP_SUBI: res_o = sum[7:0];
      default: res_o = mem_i;
    endcase
    zero_o = swx_is_zero(res_o);
  end
endmodule
`default_nettype wire

// *** swx_rom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// program rom partner model
// --------------------------------
module swx_rom_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [13:0] addr_i,
  output logic      [15:0] data_o
);
  // content pattern is arbitrary, high byte comes from address bits 7:0, low byte from bits 13:6
  function automatic logic [15:0] word(input logic [13:0] a);
    return {a[7:0] ^ 8'h5a, a[13:6] ^ 8'hc3};
  endfunction

  initial data_o = 16'h0000;

  // synchronous read; outside the read slot the bus toggles, so stale data is never trusted
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= word(addr_i);
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "swx_params.svh"
module testbench;
  import swx_pkg::*;
  logic        clk_i      = 1'b0;
  logic        reset_i    = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        rom_rd_o;
  logic [13:0] rom_addr_o;
  logic [15:0] rom_data_i;
  logic [32:0] exp_q[$];
  int          fails      = 0;
  int          num_checks = 0;
  logic [7:0]  lfsr       = 8'h37;
  logic [7:0]  eh         = 8'h00;
  logic        z          = 1'b0;

  always #5 clk_i = ~clk_i;

  swx_exec dut_u (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .psel_i     (psel),
    .penable_i  (penable),
    .pwrite_i   (pwrite),
    .paddr_i    (paddr),
    .pwdata_i   (pwdata),
    .prdata_o   (prdata_o),
    .pready_o   (pready_o),
    .pslverr_o  (pslverr_o),
    .rom_addr_o (rom_addr_o),
    .rom_rd_o   (rom_rd_o),
    .rom_data_i (rom_data_i)
  );

  swx_rom_model rom_u (
    .clk_i  (clk_i),
    .rd_i   (rom_rd_o),
    .addr_i (rom_addr_o),
    .data_o (rom_data_i)
  );

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at a rising edge; idle edge between transfers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, {1'b0, 24'h0, e});
  endtask

  // --------------------------------
  // monitor: oldest note against each answer
  // --------------------------------
  always @(posedge clk_i) begin
    if (psel && penable && pready_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] t=%0t unexpected answer got %h exp %h", $time, {pslverr_o, prdata_o}, 33'h0);
      end else begin
        check(pwrite ? {pslverr_o, 32'h0} : {pslverr_o, prdata_o}, exp_q.pop_front());
      end
    end
  end

  // --------------------------------
  // one instruction with preset operands
  // --------------------------------
  task automatic exec(input logic [3:0] op, input logic [2:0] b);
    logic [7:0]  m, acc, a, imm, tp, th, pre, ea, em, es;
    logic [8:0]  s;
    logic [15:0] w;
    logic        sk;
    m   = rnd();
    acc = rnd();
    imm = rnd();
    a   = rnd() % 8'd192;
    tp  = rnd();
    th  = rnd() & 8'h3f;
    pre = rnd() & 8'h0f;
    // zero pass forces null byte and zero results
    if (z) begin
      m   = 8'h00;
      acc = 8'h00;
      imm = 8'h00;
    end
    ea = acc;
    em = m;
    es = pre;
    sk = 1'b0;
    case (op)
      4'h0: em = {m[3:0], m[7:4]};
      4'h1: ea = {m[3:0], m[7:4]};
      4'h2: sk = (m == 8'h00);
      4'h3: begin
        ea = m;
        sk = (m == 8'h00);
      end
      4'h4: sk = !m[b];
      4'h5, 4'h6: begin
        w  = rom_u.word({(op == 4'h6) ? `SWX_LAST_PAGE : th[5:0], tp});
        em = w[7:0];
        eh = w[15:8];
      end
      4'h7: ea = acc ^ m;
      4'h8: em = acc ^ m;
      4'h9: ea = acc ^ imm;
      4'ha: begin
        s     = {1'b0, acc} + {1'b0, ~imm} + 9'h001;
        ea    = s[7:0];
        es[1] = s[8];
        es[2] = ({1'b0, acc[3:0]} + {1'b0, ~imm[3:0]} + 5'h01) > 5'h0f;
        es[3] = (acc[7] != imm[7]) && (ea[7] != acc[7]);
      end
      default: ;
    endcase
    if (op >= 4'h7 && op <= 4'ha) begin
      es[0] = (((op == 4'h8) ? em : ea) == 8'h00);
    end
    es[4] = sk;
    wr(`SWX_REG_ACC, acc);
    wr(`SWX_REG_MADDR, a);
    wr(`SWX_REG_MDATA, m);
    wr(`SWX_REG_TABLE_POINTER_LOW, tp);
    wr(`SWX_REG_TABLE_POINTER_HIGH, th);
    wr(`SWX_REG_STATUS, pre);
    apb(1'b1, `SWX_REG_INSTR, {8'h00, imm, a, 1'b0, b, op}, 33'h0);
    rd(`SWX_REG_ACC, ea);
    rd(`SWX_REG_MDATA, em);
    rd(`SWX_REG_STATUS, es);
    rd(`SWX_REG_TABLE_HIGH_LATCH, eh);
    $display("test op %0d done", op);
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`SWX_REG_ACC, 8'h00);
    rd(`SWX_REG_STATUS, 8'h00);
    rd(`SWX_REG_TABLE_HIGH_LATCH, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      z = (i == 1);
      exec(4'h0, 3'h0);
      exec(4'h1, 3'h0);
      exec(4'h2, 3'h0);
      exec(4'h3, 3'h0);
      exec(4'h4, lfsr[2:0]);
      exec(4'h5, 3'h0);
      exec(4'h6, 3'h0);
      exec(4'h7, 3'h0);
      exec(4'h8, 3'h0);
      exec(4'h9, 3'h0);
      exec(4'ha, 3'h0);
      exec(4'hb, 3'h0);
    end
    wr(`SWX_REG_TABLE_HIGH_LATCH, 8'hff);
    rd(`SWX_REG_TABLE_HIGH_LATCH, eh);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h02, 32'h5, {1'b1, 32'h0});
    $display("test refused access done");
    // mid-run reset clears accumulator, flags and pointers
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`SWX_REG_ACC, 8'h00);
    rd(`SWX_REG_STATUS, 8'h00);
    rd(`SWX_REG_TABLE_HIGH_LATCH, 8'h00);
    rd(`SWX_REG_TABLE_POINTER_LOW, 8'h00);
    $display("test reset done");
    repeat (2) @(posedge clk_i);
    finish_test();
  end

  // about 540 transfers of some 4 cycles each (11 per op), far below this
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
